// ==== design/hdlc_fifo_chan.v ====
// receive/transmit fifo control of one hdlc channel
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "hdlc_fifo_defines.vh"

module hdlc_fifo_chan #(
    parameter D_CHAN = 1
) (
    input wire mclk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire rx_start_i,
    input wire [7:0] rx_byte_i,
    input wire rx_byte_valid_i,
    input wire rx_end_i,
    input wire rx_crc_ok_i,
    input wire rx_valid_i,
    input wire rx_abort_i,
    input wire rx_cr_i,
    input wire [1:0] rx_hi_match_i,
    input wire rx_lo_match_i,
    input wire tx_req_i,
    input wire tx_collision_i,
    input wire tx_closed_i,
    output reg tx_valid_o,
    output reg [7:0] tx_data_o,
    output reg tx_sof_o,
    output reg tx_eof_o,
    output reg tx_crc_en_o,
    output reg tx_abort_o
);

    // channel geometry
    localparam [7:0] DEPTH = D_CHAN ? `D_DEPTH : `B_DEPTH;
    localparam [6:0] PMASK = D_CHAN ? `D_MASK : `B_MASK;
    localparam [6:0] RBS_MAX = D_CHAN ? `RBS_D_MAX : `RBS_B_MAX;
    localparam [6:0] XBS_MAX = D_CHAN ? `XBS_D_MAX : `XBS_B_MAX;

    // reset synchroniser, second stage is the internal reset
    reg rst_s1_q;
    reg rst_s2_q;
    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;

    // software registers
    reg [7:0] ext_q; // block sizes and crc option
    reg [7:0] mode_q; // operating mode
    reg [7:0] irq_q; // sticky interrupt indications

    // receive storage and state
    reg [7:0] rx_mem [0:127];
    reg [127:0] rx_eof_q; // marks status bytes
    reg [6:0] rx_wr_q; // write pointer
    reg [6:0] rx_base_q; // start of current block
    reg [6:0] rx_rp_q; // host read pointer
    reg [6:0] rx_scan_q; // block-length scan pointer
    reg [6:0] rx_slen_q; // bytes scanned in block
    reg [6:0] rx_blen_q; // length of announced block
    reg [6:0] rx_off_q; // bytes host has read
    reg [6:0] rx_bs_q; // active block size
    reg [7:0] rx_used_q; // occupied entries
    reg rx_pend_q; // block announced, awaiting ack
    reg rx_isend_q; // announced block ends a frame
    reg rx_lost_q; // current frame being dropped
    reg rx_rdo_q; // bytes of this frame dropped
    reg [11:0] rx_cnt_q; // frame byte count
    reg rx_ov_q; // count overflow
    reg [7:0] rx_last_q; // last byte handed to host

    // transmit storage and state
    reg [7:0] tx_mem [0:127];
    reg [127:0] tx_sof_q; // first byte of a frame
    reg [127:0] tx_eof_q; // last byte of a frame
    reg [6:0] tx_wr_q; // host write pointer
    reg [6:0] tx_rd_q; // send pointer
    reg [6:0] tx_cmt_q; // end of committed data
    reg [6:0] tx_fst_q; // first byte of frame on air
    reg [6:0] tx_wcnt_q; // bytes written since command
    reg [6:0] tx_sent_q; // bytes sent in current block
    reg [6:0] tx_bs_q; // active block size
    reg [7:0] tx_used_q; // occupied entries
    reg tx_nfr_q; // next byte opens a frame
    reg tx_act_q; // frame on air
    reg tx_fsent_q; // first block has left the fifo
    reg tx_lock_q; // locked by underrun or repeat
    reg tx_hold_q; // locked until closing flag
    reg tx_arm_q; // pool ready waits for space
    reg tx_abp_q; // abort owed to serialiser
    reg tx_tx_data_overflow_flag_q; // host overwrote data

    // bus decode
    wire wr_fifo = wr_i & (addr_i == `A_FIFO);
    wire wr_cmd = wr_i & (addr_i == `A_CMD);
    wire rd_fifo = rd_i & (addr_i == `A_FIFO);
    wire rd_irq = rd_i & (addr_i == `A_IRQ);
    wire cmd_rmc = wr_cmd & wdata_i[`CMD_RMC];
    wire cmd_rres = wr_cmd & wdata_i[`CMD_RRES];
    wire cmd_xtf = wr_cmd & wdata_i[`CMD_XTF] & ~tx_lock_q;
    wire cmd_xme = wr_cmd & wdata_i[`CMD_XME] & ~tx_lock_q;
    wire cmd_tx_reset_cmd = wr_cmd & wdata_i[`CMD_TX_RESET_CMD];

    // block sizes from the software field, largest size is code 0
    wire [6:0] rbs_new = RBS_MAX >> ext_q[`EXT_RX_BLOCK_SIZE_SEL_HI:`EXT_RX_BLOCK_SIZE_SEL_LO];
    wire [6:0] xbs_new = XBS_MAX >> ext_q[`EXT_TX_BLOCK_SIZE_SEL];

    // receive write side; one entry is always kept for the status byte
    wire rx_room = rx_used_q < (DEPTH - 8'h01);
    wire rx_data = rx_byte_valid_i & ~rx_start_i & ~rx_end_i & ~rx_lost_q;
    wire rx_put_byte = rx_data & rx_room;
    wire rx_cut = rx_data & ~rx_room;
    wire rx_put_stat = rx_end_i & ~rx_start_i & ~rx_lost_q;
    wire rx_put = rx_put_byte | rx_put_stat;
    wire rx_lose = rx_start_i & ~rx_room;

    // status byte content depends on the operating mode
    wire hi_mode = (mode_q[2:0] == `MDS_NA2) | (mode_q[2:0] == `MDS_TR1);
    wire lo_mode = mode_q[2:0] != `MDS_TR0;
    wire [7:0] rx_stat = {rx_valid_i, rx_rdo_q, rx_crc_ok_i, rx_abort_i,
        rx_hi_match_i & {2{hi_mode}}, rx_cr_i & hi_mode,
        rx_lo_match_i & lo_mode};

    // block scan: walks one entry a cycle to find full block or frame end
    wire rx_ann_full = ~rx_pend_q & (rx_slen_q == rx_bs_q);
    wire rx_scan_ok = ~rx_pend_q & ~rx_ann_full &
        ({1'b0, rx_slen_q} < rx_used_q);
    wire rx_ann_end = rx_scan_ok & rx_eof_q[rx_scan_q];
    wire rx_ann = rx_ann_full | rx_ann_end;
    wire [6:0] rx_alen = rx_ann_end ? rx_slen_q + 7'h01 : rx_slen_q;
    wire [12:0] rx_sum = {1'b0, rx_cnt_q} + {6'h00, rx_alen};
    wire rx_rel = cmd_rmc & rx_pend_q;
    wire [7:0] rx_used_d = rx_used_q + {7'h00, rx_put} -
        (rx_rel ? {1'b0, rx_blen_q} : 8'h00);
    wire [6:0] rx_nbase = (rx_base_q + rx_blen_q) & PMASK;

    // host fifo read: new byte only inside an announced block
    wire rx_rd_new = rd_fifo & rx_pend_q & (rx_off_q < rx_blen_q);
    wire [7:0] rx_rd_val = rx_rd_new ? rx_mem[rx_rp_q] : rx_last_q;

    // receive process
    always @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_eof_q <= 128'h0;
            rx_wr_q <= 7'h00;
            rx_base_q <= 7'h00;
            rx_rp_q <= 7'h00;
            rx_scan_q <= 7'h00;
            rx_slen_q <= 7'h00;
            rx_blen_q <= 7'h00;
            rx_off_q <= 7'h00;
            rx_bs_q <= RBS_MAX;
            rx_used_q <= 8'h00;
            rx_pend_q <= 1'b0;
            rx_isend_q <= 1'b0;
            rx_lost_q <= 1'b0;
            rx_rdo_q <= 1'b0;
            rx_cnt_q <= 12'h000;
            rx_ov_q <= 1'b0;
            rx_last_q <= 8'h00;
        end
        else if (ce_i)
        begin
            // frame bookkeeping
            if (rx_start_i)
            begin
                rx_lost_q <= rx_lose;
                rx_rdo_q <= 1'b0;
            end
            else if (rx_end_i)
                rx_lost_q <= 1'b0;
            else if (rx_cut)
                rx_rdo_q <= 1'b1;
            // store data or status byte
            if (rx_put)
            begin
                rx_mem[rx_wr_q] <= rx_put_stat ? rx_stat : rx_byte_i;
                rx_eof_q[rx_wr_q] <= rx_put_stat;
                rx_wr_q <= (rx_wr_q + 7'h01) & PMASK;
            end
            rx_used_q <= rx_used_d;
            // scanning and announcing
            if (rx_ann)
            begin
                rx_pend_q <= 1'b1;
                rx_isend_q <= rx_ann_end;
                rx_blen_q <= rx_alen;
                rx_off_q <= 7'h00;
                rx_cnt_q <= rx_sum[11:0];
                if (rx_sum[12])
                    rx_ov_q <= 1'b1;
            end
            else if (rx_scan_ok)
            begin
                rx_slen_q <= rx_slen_q + 7'h01;
                rx_scan_q <= (rx_scan_q + 7'h01) & PMASK;
            end
            // host reads; past the block the last byte repeats
            if (rx_rd_new)
            begin
                rx_last_q <= rx_rd_val;
                rx_rp_q <= (rx_rp_q + 7'h01) & PMASK;
                rx_off_q <= rx_off_q + 7'h01;
            end
            // acknowledge drops the whole block, read or not
            if (cmd_rmc)
            begin
                rx_bs_q <= rbs_new;
                if (rx_pend_q)
                begin
                    rx_base_q <= rx_nbase;
                    rx_rp_q <= rx_nbase;
                    rx_scan_q <= rx_nbase;
                    rx_slen_q <= 7'h00;
                    rx_pend_q <= 1'b0;
                    if (rx_isend_q)
                    begin
                        rx_cnt_q <= 12'h000;
                        rx_ov_q <= 1'b0;
                    end
                end
            end
            // receiver reset empties the fifo, irqs stay
            if (cmd_rres)
            begin
                rx_bs_q <= rbs_new;
                rx_wr_q <= 7'h00;
                rx_base_q <= 7'h00;
                rx_rp_q <= 7'h00;
                rx_scan_q <= 7'h00;
                rx_slen_q <= 7'h00;
                rx_used_q <= 8'h00;
                rx_pend_q <= 1'b0;
                rx_lost_q <= 1'b1;
                rx_cnt_q <= 12'h000;
                rx_ov_q <= 1'b0;
            end
        end
    end

    // transmit decisions
    wire tx_full = tx_used_q == DEPTH;
    wire tx_wlock = tx_lock_q | tx_hold_q;
    wire tx_put = wr_fifo & ~tx_wlock & ~tx_full;
    wire tx_ovr = wr_fifo & ~tx_wlock & (tx_full | (tx_wcnt_q >= tx_bs_q));
    wire tx_have = tx_rd_q != tx_cmt_q;
    wire tx_coll = (D_CHAN != 0) & tx_collision_i & tx_act_q;
    wire tx_rep = tx_coll & tx_fsent_q;
    wire tx_retry = tx_coll & ~tx_fsent_q;
    wire tx_go = tx_req_i & ~tx_coll;
    wire tx_abt = tx_go & tx_abp_q;
    wire tx_send = tx_go & ~tx_abp_q & tx_have;
    wire tx_udr = tx_go & ~tx_abp_q & ~tx_have & tx_act_q;
    wire tx_is_eof = tx_eof_q[tx_rd_q];
    wire tx_blk_done = tx_send & ((tx_sent_q + 7'h01) == tx_bs_q);
    wire tx_release = tx_blk_done | (tx_send & tx_is_eof);
    wire [7:0] tx_rel_n = tx_release ? {1'b0, tx_sent_q} + 8'h01 : 8'h00;
    wire [7:0] tx_used_d = tx_used_q + {7'h00, tx_put} - tx_rel_n;
    wire tx_free_ok = (DEPTH - tx_used_q) >= {1'b0, tx_bs_q};
    wire tx_clr = cmd_tx_reset_cmd | tx_udr | tx_rep;
    wire tx_xpr = (tx_arm_q & ~tx_wlock & tx_free_ok) |
        (tx_hold_q & tx_closed_i) | cmd_tx_reset_cmd;
    wire tx_xfw = ~tx_wlock & ~tx_full & (tx_wcnt_q < tx_bs_q);
    wire [6:0] tx_prev = (tx_wr_q - 7'h01) & PMASK;

    // transmit process
    always @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_sof_q <= 128'h0;
            tx_eof_q <= 128'h0;
            tx_wr_q <= 7'h00;
            tx_rd_q <= 7'h00;
            tx_cmt_q <= 7'h00;
            tx_fst_q <= 7'h00;
            tx_wcnt_q <= 7'h00;
            tx_sent_q <= 7'h00;
            tx_bs_q <= XBS_MAX;
            tx_used_q <= 8'h00;
            tx_nfr_q <= 1'b1;
            tx_act_q <= 1'b0;
            tx_fsent_q <= 1'b0;
            tx_lock_q <= 1'b0;
            tx_hold_q <= 1'b0;
            tx_arm_q <= 1'b0;
            tx_abp_q <= 1'b0;
            tx_tx_data_overflow_flag_q <= 1'b0;
            tx_valid_o <= 1'b0;
            tx_data_o <= 8'h00;
            tx_sof_o <= 1'b0;
            tx_eof_o <= 1'b0;
            tx_crc_en_o <= 1'b0;
            tx_abort_o <= 1'b0;
        end
        else if (ce_i)
        begin
            // host writes; first byte after a frame end opens a frame
            if (tx_put)
            begin
                tx_mem[tx_wr_q] <= wdata_i;
                tx_sof_q[tx_wr_q] <= tx_nfr_q;
                tx_eof_q[tx_wr_q] <= 1'b0;
                tx_nfr_q <= 1'b0;
                tx_wr_q <= (tx_wr_q + 7'h01) & PMASK;
                tx_wcnt_q <= tx_wcnt_q + 7'h01;
            end
            if (tx_ovr)
                tx_tx_data_overflow_flag_q <= 1'b1;
            tx_used_q <= tx_used_d;
            // pool ready retires the wait; a command in the same cycle wins
            if (tx_xpr)
            begin
                tx_arm_q <= 1'b0;
                tx_hold_q <= 1'b0;
            end
            // frame and end commands commit the written block
            if (cmd_xtf | cmd_xme)
            begin
                tx_cmt_q <= tx_wr_q;
                tx_wcnt_q <= 7'h00;
                tx_bs_q <= xbs_new;
                tx_hold_q <= cmd_xtf & cmd_xme;
                tx_arm_q <= ~(cmd_xtf & cmd_xme);
            end
            if (cmd_xme)
            begin
                tx_eof_q[tx_prev] <= 1'b1;
                tx_nfr_q <= 1'b1;
            end
            // serialiser answer, one cycle after its request
            tx_valid_o <= tx_send | tx_udr | tx_abt;
            tx_abort_o <= tx_udr | tx_abt;
            tx_sof_o <= tx_send & tx_sof_q[tx_rd_q];
            tx_eof_o <= tx_send & tx_is_eof;
            tx_crc_en_o <= ~ext_q[`EXT_XCRC_OFF];
            if (tx_send)
                tx_data_o <= tx_mem[tx_rd_q];
            if (tx_abt)
                tx_abp_q <= 1'b0;
            if (tx_send)
            begin
                tx_rd_q <= (tx_rd_q + 7'h01) & PMASK;
                if (tx_sof_q[tx_rd_q])
                begin
                    tx_act_q <= 1'b1;
                    tx_fst_q <= tx_rd_q;
                end
                // space is freed a whole block at a time, the rest of a frame at its last byte
                if (tx_release)
                    tx_sent_q <= 7'h00;
                else
                    tx_sent_q <= tx_sent_q + 7'h01;
                if (tx_blk_done)
                    tx_fsent_q <= 1'b1;
                if (tx_is_eof)
                begin
                    tx_act_q <= 1'b0;
                    tx_fsent_q <= 1'b0;
                end
            end
            // early collision: first block still held, resend it
            if (tx_retry)
            begin
                tx_rd_q <= tx_fst_q;
                tx_sent_q <= 7'h00;
            end
            // lock lifts once the irq status has been read
            if (rd_irq)
                tx_lock_q <= 1'b0;
            // underrun, repeat and reset empty the fifo
            if (tx_clr)
            begin
                tx_wr_q <= 7'h00;
                tx_rd_q <= 7'h00;
                tx_cmt_q <= 7'h00;
                tx_wcnt_q <= 7'h00;
                tx_sent_q <= 7'h00;
                tx_used_q <= 8'h00;
                tx_nfr_q <= 1'b1;
                tx_act_q <= 1'b0;
                tx_fsent_q <= 1'b0;
                tx_hold_q <= 1'b0;
                tx_arm_q <= 1'b0;
            end
            if (tx_udr | tx_rep)
                tx_lock_q <= 1'b1;
            if (tx_rep | cmd_tx_reset_cmd)
                tx_abp_q <= 1'b1;
            if (cmd_tx_reset_cmd)
            begin
                tx_bs_q <= xbs_new;
                tx_tx_data_overflow_flag_q <= 1'b0;
            end
        end
    end

    // irq set vector; a set in the read cycle survives the clear
    wire [7:0] irq_set;
    assign irq_set[`IRQ_RME] = rx_ann_end;
    assign irq_set[`IRQ_RPF] = rx_ann_full;
    assign irq_set[`IRQ_RFO] = rx_lose;
    assign irq_set[`IRQ_XPR] = tx_xpr;
    assign irq_set[`IRQ_XDU] = tx_udr;
    assign irq_set[`IRQ_XMR] = tx_rep;
    assign irq_set[1:0] = 2'b00;

    // read mux
    reg [7:0] rd_val;
    always @*
    begin
        case (addr_i)
            `A_FIFO: rd_val = rx_rd_val;
            `A_IRQ: rd_val = irq_q;
            `A_STAT: rd_val = {1'b0, tx_tx_data_overflow_flag_q, tx_xfw, 5'h00};
            `A_EXT: rd_val = ext_q;
            `A_MODE: rd_val = mode_q;
            `A_CNTL: rd_val = rx_cnt_q[7:0];
            `A_CNTH: rd_val = {rx_ov_q, 3'h0, rx_cnt_q[11:8]};
            default: rd_val = 8'h00;
        endcase
    end

    // register bank and read data
    always @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_q <= `EXT_RST;
            mode_q <= `MODE_RST;
            irq_q <= 8'h00;
            rdata_o <= 8'h00;
        end
        else if (ce_i)
        begin
            if (wr_i & (addr_i == `A_EXT))
                ext_q <= wdata_i;
            if (wr_i & (addr_i == `A_MODE))
                mode_q <= wdata_i;
            // reading clears; tx_reset_cmd leaves pending bits alone
            irq_q <= (irq_q & ~(rd_irq ? irq_q : 8'h00)) | irq_set;
            rdata_o <= rd_i ? rd_val : 8'h00;
        end
    end

endmodule

// ==== design/hdlc_fifo_defines.vh ====
// register map, field positions, reset values and sizes of the fifo channel
`ifndef HDLC_FIFO_DEFINES_VH
`define HDLC_FIFO_DEFINES_VH

// register addresses (3-bit word index)
`define A_FIFO 3'h0
`define A_CMD 3'h1
`define A_IRQ 3'h2
`define A_STAT 3'h3
`define A_EXT 3'h4
`define A_MODE 3'h5
`define A_CNTL 3'h6
`define A_CNTH 3'h7

// chan_command_reg bit positions
`define CMD_RMC 7
`define CMD_RRES 6
`define CMD_XTF 3
`define CMD_XME 1
`define CMD_TX_RESET_CMD 0

// chan_irq_status bit positions
`define IRQ_RME 7
`define IRQ_RPF 6
`define IRQ_RFO 5
`define IRQ_XPR 4
`define IRQ_XDU 3
`define IRQ_XMR 2

// chan_status_reg bit positions
`define STAT_TX_DATA_OVERFLOW_FLAG 6
`define STAT_XFW 5

// ext_mode_reg fields
`define EXT_RX_BLOCK_SIZE_SEL_HI 7
`define EXT_RX_BLOCK_SIZE_SEL_LO 6
`define EXT_TX_BLOCK_SIZE_SEL 5
`define EXT_XCRC_OFF 4

// reset values
`define EXT_RST 8'h00
`define MODE_RST 8'h00

// operating mode codes
`define MDS_NA2 3'h3
`define MDS_TR0 3'h6
`define MDS_TR1 3'h7

// fifo depths and largest block sizes
`define D_DEPTH 8'h40
`define B_DEPTH 8'h80
`define D_MASK 7'h3F
`define B_MASK 7'h7F
`define RBS_D_MAX 7'h20
`define RBS_B_MAX 7'h40
`define XBS_D_MAX 7'h20
`define XBS_B_MAX 7'h40

`endif

// ==== verif/hdlc_fifo_chan_assertions.sv ====
// port checker for the fifo channel
`timescale 1ns/1ps
`include "hdlc_fifo_defines.vh"
module hdlc_fifo_chan_chk (
    input wire mclk_i,
    input wire rst_n_i,
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire tx_req_i,
    input wire tx_valid_o,
    input wire tx_sof_o,
    input wire tx_eof_o,
    input wire tx_crc_en_o,
    input wire tx_abort_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    // answers come one cycle after a request, never unasked
    valid_req_a: assert property (
        tx_valid_o |-> $past(tx_req_i)) else $error("unasked valid");
    sof_valid_a: assert property (
        tx_sof_o |-> tx_valid_o && !tx_abort_o) else $error("stray sof");
    eof_valid_a: assert property (
        tx_eof_o |-> tx_valid_o && !tx_abort_o) else $error("stray eof");
    // an abort carries no opening mark
    abort_alone_a: assert property (
        tx_abort_o |-> tx_valid_o && !tx_sof_o) else $error("stray abort");
    // crc enable follows the ext write, registered once more
    crc_follow_a: assert property (
        $past(wr_i && addr_i == `A_EXT, 2) |->
        tx_crc_en_o == !$past(wdata_i[`EXT_XCRC_OFF], 2))
        else $error("crc enable stale");
    // spare bits 4:0 of status, and the spare bits of irq and count high, read as zero
    stat_bits_a: assert property (
        rd_i && addr_i == `A_STAT |=> rdata_o[4:0] == 5'h00)
        else $error("status spare bits set");
    irq_bits_a: assert property (
        rd_i && addr_i == `A_IRQ |=> rdata_o[1:0] == 2'h0)
        else $error("irq spare bits set");
    cnt_high_a: assert property (
        rd_i && addr_i == `A_CNTH |=> rdata_o[6:4] == 3'h0)
        else $error("count high spare bits set");
endmodule

bind hdlc_fifo_chan hdlc_fifo_chan_chk u_chk (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .tx_req_i(tx_req_i),
    .tx_valid_o(tx_valid_o), .tx_sof_o(tx_sof_o), .tx_eof_o(tx_eof_o),
    .tx_crc_en_o(tx_crc_en_o), .tx_abort_o(tx_abort_o));

// ==== verif/hdlc_fifo_chan_tb.sv ====
// random and corner tests of one fifo channel
`timescale 1ns/1ps
`include "hdlc_fifo_defines.vh"
module hdlc_fifo_chan_tb;
    reg mclk_i, rst_n_i, wr_i, rd_i, en, slow, coll;
    reg rx_start_i, rx_byte_valid_i, rx_end_i;
    reg [2:0] addr_i, m;
    reg [7:0] wdata_i, rx_byte_i, d, n;
    reg [6:0] st; // crc, valid, abort, c/r, high[1:0], low
    wire [7:0] rdata_o, tx_data_o;
    wire tx_valid_o, tx_sof_o, tx_eof_o, tx_crc_en_o, tx_abort_o;
    wire tx_req, tx_closed;
    integer n_fail = 0;
    integer num_checks = 0;
    integer cyc = 0;
    integer i, k;
    reg [10:0] q[$]; // abort, eof, sof and data of each answer
    reg [7:0] b[$]; // bytes handed over
    hdlc_fifo_chan #(.D_CHAN(1)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .rx_start_i(rx_start_i),
        .rx_byte_i(rx_byte_i), .rx_byte_valid_i(rx_byte_valid_i),
        .rx_end_i(rx_end_i), .rx_crc_ok_i(st[6]), .rx_valid_i(st[5]),
        .rx_abort_i(st[4]), .rx_cr_i(st[3]), .rx_hi_match_i(st[2:1]),
        .rx_lo_match_i(st[0]), .tx_req_i(tx_req), .tx_collision_i(coll),
        .tx_closed_i(tx_closed), .tx_valid_o(tx_valid_o),
        .tx_data_o(tx_data_o), .tx_sof_o(tx_sof_o), .tx_eof_o(tx_eof_o),
        .tx_crc_en_o(tx_crc_en_o), .tx_abort_o(tx_abort_o));
    hdlc_serial_model far (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .en_i(en),
        .slow_i(slow), .eof_i(tx_eof_o), .req_o(tx_req),
        .closed_o(tx_closed));
    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    // hang guard
    always @(posedge mclk_i)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            n_fail = n_fail + 1;
            conclude;
        end
    end
    // log every answer of the transmit side
    always @(posedge mclk_i)
        if (tx_valid_o)
            q.push_back({tx_abort_o, tx_eof_o, tx_sof_o, tx_data_o});
    task conclude;
    begin
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
        num_checks = num_checks + 1;
        if (g !== e)
        begin
            n_fail = n_fail + 1;
            $display("Error %0s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    task wr(input [2:0] a, input [7:0] v);
    begin
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    end
    endtask
    // read, data taken in the one cycle it stands, masked compare
    task rdc(input [2:0] a, input [7:0] mk, input [7:0] e, input string nm);
    begin
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk(nm, e & mk, rdata_o & mk);
    end
    endtask
    task waitq(input integer c);
        for (k = 0; k < 900 && q.size() < c; k = k + 1)
            @(posedge mclk_i);
    endtask
    // start, stored bytes of b, end with status levels of st
    task rxframe(input integer len);
    begin
        @(posedge mclk_i);
        rx_start_i <= 1'b1;
        for (k = 0; k < len; k = k + 1)
        begin
            @(posedge mclk_i);
            rx_start_i <= 1'b0;
            rx_byte_valid_i <= 1'b1;
            rx_byte_i <= b[k];
        end
        @(posedge mclk_i);
        rx_start_i <= 1'b0;
        rx_byte_valid_i <= 1'b0;
        rx_end_i <= 1'b1;
        @(posedge mclk_i);
        rx_end_i <= 1'b0;
    end
    endtask
    // status byte expected in mode md
    function [7:0] stat_f(input [2:0] md, input [6:0] s);
    begin
        stat_f = {s[5], 1'b0, s[6], s[4], 4'h0};
        if (md == `MDS_NA2 || md == `MDS_TR1)
            stat_f[3:1] = {s[2:1], s[3]};
        if (md != `MDS_TR0)
            stat_f[0] = s[0];
    end
    endfunction
    initial
    begin
        rst_n_i = 1'b0;
        {addr_i, wdata_i, wr_i, rd_i, rx_start_i, rx_byte_i} = 0;
        {rx_byte_valid_i, rx_end_i, st, en, slow, coll} = 0;
        d = $urandom(32'h51cb);
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rdc(`A_IRQ, 8'hFF, 8'h00, "irq");
        rdc(`A_EXT, 8'hFF, `EXT_RST, "ext");
        rdc(`A_MODE, 8'hFF, `MODE_RST, "mode");
        wr(`A_CMD, 8'h01);
        rdc(`A_IRQ, 8'h10, 8'h10, "pool ready");
        rdc(`A_IRQ, 8'h10, 8'h00, "irq cleared");
        rdc(`A_STAT, 8'h20, 8'h20, "write enable");
        $display("reset test done");
        // whole frame in one block with both commands, crc off
        wr(`A_EXT, 8'h10);
        n = 8'(1 + $urandom % 32);
        for (i = 0; i < n; i = i + 1)
        begin
            d = $urandom;
            b.push_back(d);
            wr(`A_FIFO, d);
        end
        wr(`A_CMD, 8'h0A);
        rdc(`A_IRQ, 8'h10, 8'h00, "early ready");
        en <= 1'b1;
        waitq(n + 1);
        for (k = 0; k < 60 && !tx_closed; k = k + 1)
            @(posedge mclk_i);
        en <= 1'b0;
        chk("tx_reset_cmd abort", 8'h04, {5'h0, q[0][10:8]});
        q.delete(0);
        for (i = 0; i < n; i = i + 1)
        begin
            chk("tx byte", b[i], q[i][7:0]);
            chk("tx flags", {6'h0, i == n - 1, i == 0}, q[i][10:8]);
        end
        rdc(`A_IRQ, 8'h10, 8'h10, "late ready");
        wr(`A_EXT, `EXT_RST);
        $display("frame test done");
        // short block, slow pull, runs dry mid frame
        q.delete();
        slow <= 1'b1;
        for (i = 0; i < 4; i = i + 1)
            wr(`A_FIFO, 8'(i));
        wr(`A_CMD, 8'h08);
        en <= 1'b1;
        waitq(5);
        en <= 1'b0;
        chk("abort", 8'h04, {5'h0, q[4][10:8]});
        rdc(`A_STAT, 8'h20, 8'h00, "locked");
        rdc(`A_IRQ, 8'h08, 8'h08, "underrun");
        rdc(`A_STAT, 8'h20, 8'h20, "unlocked");
        $display("underrun test done");
        // one byte past the block size
        wr(`A_CMD, 8'h01);
        for (i = 0; i < 33; i = i + 1)
            wr(`A_FIFO, 8'(i));
        rdc(`A_STAT, 8'h40, 8'h40, "data overflow");
        wr(`A_CMD, 8'h01);
        $display("overflow test done");
        // collision once the first block has gone
        q.delete();
        for (i = 0; i < 32; i = i + 1)
            wr(`A_FIFO, 8'(i));
        wr(`A_CMD, 8'h08);
        en <= 1'b1;
        waitq(33);
        coll <= 1'b1;
        @(posedge mclk_i);
        coll <= 1'b0;
        en <= 1'b0;
        rdc(`A_IRQ, 8'h04, 8'h04, "repeat");
        $display("repeat test done");
        // one frame per mode; status byte, count, repeat, ack
        for (i = 0; i < 4; i = i + 1)
        begin
            m = i == 0 ? 3'h0 : i == 1 ? `MDS_NA2 : i == 2 ? `MDS_TR0 : `MDS_TR1;
            wr(`A_MODE, {5'h00, m});
            wr(`A_CMD, 8'h40);
            n = 8'(1 + $urandom % 20);
            b.delete();
            repeat (n) b.push_back(8'($urandom));
            st <= 7'($urandom);
            rxframe(n);
            repeat (40) @(posedge mclk_i);
            rdc(`A_IRQ, 8'h80, 8'h80, "frame end");
            rdc(`A_CNTL, 8'hFF, n + 8'h01, "count");
            rdc(`A_CNTH, 8'hFF, 8'h00, "count high");
            for (k = 0; k < n; k = k + 1)
                rdc(`A_FIFO, 8'hFF, b[k], "rx byte");
            rdc(`A_FIFO, 8'hFF, stat_f(m, st), "status");
            rdc(`A_FIFO, 8'hFF, stat_f(m, st), "reread");
            wr(`A_CMD, 8'h80);
            rdc(`A_CNTL, 8'hFF, 8'h00, "count cleared");
        end
        $display("receive test done");
        // unread long frame fills the fifo, next frame is lost
        repeat (70) b.push_back(8'($urandom));
        rxframe(70);
        rxframe(2);
        rdc(`A_IRQ, 8'h20, 8'h20, "frame lost");
        $display("frame lost test done");
        conclude;
    end
endmodule

// ==== verif/hdlc_serial_model.sv ====
// serialiser model that pulls bytes and reports frame close
`timescale 1ns/1ps
module hdlc_serial_model (
    input wire mclk_i,
    input wire rst_n_i,
    input wire en_i,
    input wire slow_i,
    input wire eof_i,
    output reg req_o,
    output reg closed_o
);
    reg [2:0] gap_q; // spacing between requests
    reg [3:0] tail_q; // crc and closing flag still to shift
    // one request per byte slot; slow mode stretches the slot
    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gap_q <= 3'h0;
            tail_q <= 4'h0;
            req_o <= 1'b0;
            closed_o <= 1'b0;
        end
        else
        begin
            req_o <= en_i && gap_q == 3'h0;
            gap_q <= en_i ? gap_q + (slow_i ? 3'h1 : 3'h4) : 3'h0;
            // last byte out: shift crc and flag before closing
            tail_q <= eof_i ? 4'hF : tail_q - {3'h0, tail_q != 4'h0};
            closed_o <= tail_q == 4'h1;
        end
    end
endmodule
